// ---- conv_list_base_offset_regs_bench.sv ----
`timescale 1ns/1ps
module conv_list_base_offset_regs_bench;
   import cvlbo_pkg::*;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [23:0] cbp = 24'h123450;
   logic list_sel = 1'b0;
   logic [6:0] ridx = 7'h00;
   logic [6:0] cidx = 7'h00;
   logic [23:0] result_addr;
   logic [23:0] command_addr;
   logic en_o;
   logic sma_o;
   int n_errors = 0;
   int n_compared = 0;
   always #4 pclk = ~pclk;
   cvlbo_regs dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .command_base_pointer(cbp), .list_sel(list_sel),
      .result_index_counter(ridx), .command_index(cidx), .converter_enable(en_o),
      .special_mode_access_bit(sma_o), .result_addr(result_addr), .command_addr(command_addr));
   ////////////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_errors++;
         end_sim();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r, x)
      `CHK(e, xe)
   endtask : rd
   // Drive list inputs, let the registered sums settle, compare
   task automatic at(input logic s, input logic [6:0] ri, input logic [6:0] ci,
                     input logic [23:0] xr, input logic [23:0] xc);
      @(posedge pclk);
      list_sel <= s;
      ridx <= ri;
      cidx <= ci;
      repeat (2) @(posedge pclk);
      `CHK(result_addr, xr)
      `CHK(command_addr, xc)
   endtask : at
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      rd(CTRL_OFS, 32'h0, 1'b0);
      rd(OFF0_OFS, 32'h0, 1'b0);
      rd(RBP_OFS, 32'h0, 1'b0);
      rd(OFF1_OFS, 32'h0, 1'b0);
      $display("test reset done");
   endtask : t_reset
   task t_open;
      wr(RBP_OFS, 32'hFFFFFFFF);
      rd(RBP_OFS, 32'h000FFFFC, 1'b0);
      wr(OFF1_OFS, 32'hFFFFFFFF);
      rd(OFF1_OFS, 32'h0000007F, 1'b0);
      wr(OFF0_OFS, 32'h0000007F);
      rd(OFF0_OFS, 32'h0, 1'b0);
      rd(12'h100, 32'h0, 1'b1);
      $display("test open done");
   endtask : t_open
   task t_lock;
      wr(CTRL_OFS, 32'h1);
      wr(RBP_OFS, 32'h000ABCD4);
      rd(RBP_OFS, 32'h000FFFFC, 1'b0);
      wr(OFF1_OFS, 32'h5);
      rd(OFF1_OFS, 32'h0000007F, 1'b0);
      wr(CTRL_OFS, 32'h3);
      rd(CTRL_OFS, 32'h3, 1'b0);
      `CHK({sma_o, en_o}, 2'b11)
      wr(RBP_OFS, 32'h000ABCD4);
      rd(RBP_OFS, 32'h000ABCD4, 1'b0);
      wr(OFF1_OFS, 32'h5);
      rd(OFF1_OFS, 32'h5, 1'b0);
      wr(CTRL_OFS, 32'h0);
      $display("test lock done");
   endtask : t_lock
   task t_addr;
      at(1'b0, 7'h10, 7'h7F, 24'h0ABCD4 + 24'h20, 24'h123450 + 24'h1FC);
      at(1'b1, 7'h10, 7'h7F, 24'h0ABCD4 + 24'h2A, 24'h123450 + 24'h210);
      ce <= 1'b0;
      at(1'b1, 7'h00, 7'h00, 24'h0ABCD4 + 24'h2A, 24'h123450 + 24'h210);
      ce <= 1'b1;
      at(1'b1, 7'h7F, 7'h00, 24'h0ABCD4 + 24'h108, 24'h123450 + 24'h14);
      rd(RADDR_OFS, 32'h000ABDDC, 1'b0);
      rd(CADDR_OFS, 32'h00123464, 1'b0);
      $display("test addr done");
   endtask : t_addr
   // Reset in mid-run with list 1 active and a non-zero index
   task t_rerst;
      wr(CTRL_OFS, 32'h3);
      @(posedge pclk);
      list_sel <= 1'b1;
      ridx <= 7'h7F;
      cidx <= 7'h01;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK(result_addr, 24'h0)
      `CHK({sma_o, en_o}, 2'b00)
      presetn <= 1'b1;
      at(1'b1, 7'h7F, 7'h01, 24'h0000FE, 24'h123450 + 24'h4);
      rd(OFF1_OFS, 32'h0, 1'b0);
      rd(RBP_OFS, 32'h0, 1'b0);
      $display("test reset again done");
   endtask : t_rerst
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_open();
      t_lock();
      t_addr();
      t_rerst();
      end_sim();
   end
endmodule : conv_list_base_offset_regs_bench

// ---- cvlbo_addr_calc.sv ----
`timescale 1ns/1ps
module cvlbo_addr_calc #(
   parameter int SHIFT = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Address terms
   input wire logic [cvlbo_pkg::ADDR_W-1:0] base,
   input wire logic [cvlbo_pkg::OFF_W-1:0] offset,
   input wire logic [cvlbo_pkg::IDX_W-1:0] index,
   // Byte address
   output logic [cvlbo_pkg::ADDR_W-1:0] addr
);
   import cvlbo_pkg::*;

   // Offset and index are object counts, scaled to bytes
   wire logic [7:0] units = {1'b0, offset} + {1'b0, index};
   wire logic [ADDR_W-1:0] scaled = ADDR_W'(units) << SHIFT;
   wire logic [ADDR_W-1:0] addr_nxt = base + scaled;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr <= '0;
      end else if (ce) begin
         addr <= addr_nxt;
      end
   end
endmodule : cvlbo_addr_calc

// ---- cvlbo_pkg.sv ----
package cvlbo_pkg;
   // Register byte offsets on the 12-bit APB address
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] OFF0_OFS = 12'h024;
   localparam logic [11:0] RBP_OFS = 12'h028;
   localparam logic [11:0] OFF1_OFS = 12'h02C;
   localparam logic [11:0] RADDR_OFS = 12'h030;
   localparam logic [11:0] CADDR_OFS = 12'h034;
   // Widths
   localparam int ADDR_W = 24;
   localparam int OFF_W = 7;
   localparam int IDX_W = 7;
   // Field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_SMA_BIT = 1;
   localparam int RBP_LSB = 2;
   localparam int RBP_MSB = 19;
   // Writable bits of the result base pointer
   localparam logic [23:0] RBP_WMASK = 24'h0FFFFC;
   // Reset and fixed values
   localparam logic [23:0] RBP_RESET = 24'h000000;
   localparam logic [6:0] OFF1_RESET = 7'h00;
   localparam logic [6:0] OFF0_VALUE = 7'h00;
   localparam logic CTRL_EN_RESET = 1'b0;
   localparam logic CTRL_SMA_RESET = 1'b0;
   // Byte shift per list unit: 16-bit results, 32-bit commands
   localparam int RES_SHIFT = 1;
   localparam int CMD_SHIFT = 2;
endpackage : cvlbo_pkg

// ---- cvlbo_regs.sv ----
// Function
// - Result base field writes accepted only when converter disabled or special access set.
// - Result base pointer is the base of result lists in system RAM.
// - List 0 offset register is read-only; writes do nothing.
// - List 0 offset is always zero; list 0 starts at the base pointers.
// - Offsets count objects: 16-bit results, 32-bit commands.
// - List 1 uses the programmable offset against both base pointers.
// - List 1 offset writable only when disabled or special access set.
// - Selected offset applies to result stores and command fetches alike.
// - Result address is base pointer plus active offset plus result index.
`timescale 1ns/1ps
module cvlbo_regs (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter side
   input wire logic [cvlbo_pkg::ADDR_W-1:0] command_base_pointer,
   input wire logic list_sel,
   input wire logic [cvlbo_pkg::IDX_W-1:0] result_index_counter,
   input wire logic [cvlbo_pkg::IDX_W-1:0] command_index,
   output logic converter_enable,
   output logic special_mode_access_bit,
   output logic [cvlbo_pkg::ADDR_W-1:0] result_addr,
   output logic [cvlbo_pkg::ADDR_W-1:0] command_addr
);
   import cvlbo_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic en_r;
   logic sma_r;
   logic [ADDR_W-1:0] rbp_r;
   logic [OFF_W-1:0] off1_r;
   logic [31:0] prdata_r;
   logic pslverr_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode
   wire logic sel_ctrl = (paddr == CTRL_OFS);
   wire logic sel_off0 = (paddr == OFF0_OFS);
   wire logic sel_rbp = (paddr == RBP_OFS);
   wire logic sel_off1 = (paddr == OFF1_OFS);
   wire logic sel_radd = (paddr == RADDR_OFS);
   wire logic sel_cadd = (paddr == CADDR_OFS);
   wire logic mapped = sel_ctrl | sel_off0 | sel_rbp | sel_off1 | sel_radd | sel_cadd;
   wire logic setup = psel & ~penable;
   wire logic access = psel & penable & ce;
   wire logic wr = access & pwrite;
   wire logic wr_ok = ~en_r | sma_r;
   wire logic wr_ctrl = wr & sel_ctrl;
   wire logic wr_rbp = wr & sel_rbp & wr_ok;
   wire logic wr_off1 = wr & sel_off1 & wr_ok;
   wire logic [ADDR_W-1:0] rbp_nxt = pwdata[ADDR_W-1:0] & RBP_WMASK;
   wire logic [OFF_W-1:0] off1_nxt = pwdata[OFF_W-1:0];

   // Read data; list 0 offset is a constant, never written
   wire logic [31:0] prdata_nxt =
      sel_ctrl ? {30'h0, sma_r, en_r} :
      sel_off0 ? {25'h0, OFF0_VALUE} :
      sel_rbp ? {8'h0, rbp_r} :
      sel_off1 ? {25'h0, off1_r} :
      sel_radd ? {8'h0, result_addr} :
      sel_cadd ? {8'h0, command_addr} : 32'h0;

   // Active list offset for both lists
   wire logic [OFF_W-1:0] act_off = list_sel ? off1_r : OFF0_VALUE;

   assign prdata = prdata_r;
   assign pslverr = pslverr_r & access;
   assign pready = access;
   assign converter_enable = en_r;
   assign special_mode_access_bit = sma_r;

   ////////////////////////////////////////////////////////////////////////////////
   // State
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= CTRL_EN_RESET;
         sma_r <= CTRL_SMA_RESET;
      end else if (wr_ctrl) begin
         en_r <= pwdata[CTRL_EN_BIT];
         sma_r <= pwdata[CTRL_SMA_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rbp_r <= RBP_RESET;
      end else if (wr_rbp) begin
         rbp_r <= rbp_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off1_r <= OFF1_RESET;
      end else if (wr_off1) begin
         off1_r <= off1_nxt;
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
         pslverr_r <= 1'b0;
      end else if (ce && setup) begin
         prdata_r <= pwrite ? 32'h0 : prdata_nxt;
         pslverr_r <= ~mapped;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address generation
   cvlbo_addr_calc #(.SHIFT(RES_SHIFT)) u_res_addr (
      .clk(pclk),
      .rstn(presetn),
      .ce(ce),
      .base(rbp_r),
      .offset(act_off),
      .index(result_index_counter),
      .addr(result_addr)
   );

   cvlbo_addr_calc #(.SHIFT(CMD_SHIFT)) u_cmd_addr (
      .clk(pclk),
      .rstn(presetn),
      .ce(ce),
      .base(command_base_pointer),
      .offset(act_off),
      .index(command_index),
      .addr(command_addr)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_locked_rbp_write;
      wr & sel_rbp & en_r & ~sma_r;
   endsequence

   sequence s_locked_off1_write;
      wr & sel_off1 & en_r & ~sma_r;
   endsequence

   sequence s_open_rbp_write;
      wr & sel_rbp & (~en_r | sma_r);
   endsequence

   sequence s_open_off1_write;
      wr & sel_off1 & (~en_r | sma_r);
   endsequence

   a_rbp_locked: assert property (@(posedge pclk) disable iff (!presetn)
      s_locked_rbp_write |=> $stable(rbp_r))
      else $error("result base pointer changed while locked");

   a_rbp_written: assert property (@(posedge pclk) disable iff (!presetn)
      s_open_rbp_write |=> rbp_r == ($past(pwdata[23:0]) & 24'h0FFFFC))
      else $error("result base pointer write lost");

   a_off1_locked: assert property (@(posedge pclk) disable iff (!presetn)
      s_locked_off1_write |=> $stable(off1_r))
      else $error("list 1 offset changed while locked");

   a_off0_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && setup && !pwrite && sel_off0) |=> (prdata == 32'h0) && !pslverr_r)
      else $error("list 0 offset read not zero");

   a_rbp_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (rbp_r[1:0] == 2'b00) && (rbp_r[23:20] == 4'h0))
      else $error("result base pointer unimplemented bits set");

   a_res_list0: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && ce && !list_sel) |=>
         result_addr == $past(rbp_r) + (24'($past(result_index_counter)) << 1))
      else $error("list 0 result address wrong");

   a_res_list1: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && ce && list_sel) |=> result_addr ==
         $past(rbp_r) + ((24'($past(off1_r)) + 24'($past(result_index_counter))) << 1))
      else $error("list 1 result address wrong");

   a_cmd_list1: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && ce && list_sel) |=> command_addr ==
         $past(command_base_pointer) + ((24'($past(off1_r)) + 24'($past(command_index))) << 2))
      else $error("list 1 command address wrong");

   a_res_even: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> (result_addr[0] == 1'b0) &&
         (command_addr[1:0] == $past(command_base_pointer[1:0])))
      else $error("list address not object aligned");

   a_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      !ce |=> $stable(result_addr) && $stable(command_addr) && $stable(off1_r))
      else $error("state moved while clock enable low");

   a_off1_written: assert property (@(posedge pclk) disable iff (!presetn)
      s_open_off1_write |=> off1_r == $past(pwdata[6:0]))
      else $error("list 1 offset write lost");

   a_cmd_list0: assert property (@(posedge pclk) disable iff (!presetn)
      (presetn && ce && !list_sel) |=> command_addr ==
         $past(command_base_pointer) + (24'($past(command_index)) << 2))
      else $error("list 0 command address wrong");

   a_off1_read: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && setup && !pwrite && sel_off1) |=> prdata == {25'h0, $past(off1_r)})
      else $error("list 1 offset read wrong");

   a_rbp_read: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && setup && !pwrite && sel_rbp) |=> prdata == {8'h0, $past(rbp_r)})
      else $error("result base pointer read wrong");

   a_lock_silent: assert property (@(posedge pclk) disable iff (!presetn)
      (access && (sel_rbp || sel_off1)) |-> !pslverr)
      else $error("base or offset access flagged an error");
endmodule : cvlbo_regs
